// ---- hw/lux_pkg.sv ----
// lux_pkg: encodings, states and reset values for the literal/user-access execution unit
package lux_pkg;

	// instruction class field, bits 15:12
	localparam logic [3:0]  CLS_SLIT      = 4'hb;
	localparam logic [3:0]  CLS_USER      = 4'hc;
	localparam logic [3:0]  CLS_LLIT      = 4'hd;
	localparam int          CLS_MSB       = 15;
	localparam int          CLS_LSB       = 12;
	// operation / sub-select field, bits 11:8; invert flag is bit 8
	localparam int          OPF_MSB       = 11;
	localparam int          OPF_LSB       = 8;
	localparam int          INV_BIT       = 8;
	localparam int          SUB_MSB       = 11;
	localparam int          SUB_LSB       = 9;
	// form field, bits 7:6
	localparam int          FRM_MSB       = 7;
	localparam int          FRM_LSB       = 6;
	localparam logic [1:0]  FRM_PUSHALU   = 2'h0;
	localparam logic [1:0]  FRM_MISC      = 2'h1;
	localparam logic [1:0]  FRM_ALU       = 2'h2;
	// sub-select codes in bits 11:9
	localparam logic [2:0]  SUB_LOAD      = 3'h7;
	localparam logic [2:0]  SUB_FETCH     = 3'h0;
	localparam logic [2:0]  SUB_STORE     = 3'h1;
	localparam logic [2:0]  SUB_STDROP    = 3'h2;
	// 5-bit literal / user word offset, bits 4:0
	localparam int          FLD_W         = 5;
	localparam int          DATA_W        = 16;
	localparam int          PC_W          = 16;
	localparam int          PAGE_W        = 4;
	localparam int          UBASE_LSB     = 6;
	localparam int          UADDR_W       = 20;
	localparam logic [PC_W-1:0] PC_STEP1  = 16'h0001;
	localparam logic [PC_W-1:0] PC_STEP2  = 16'h0002;

	// reset values
	localparam logic [DATA_W-1:0] TOP_RST  = 16'h0000;
	localparam logic [DATA_W-1:0] NEXT_RST = 16'h0000;
	localparam logic [PC_W-1:0]   PC_RST   = 16'h0000;

	// alu operation codes
	localparam logic [3:0]  ALU_PASSB     = 4'h0;
	localparam logic [3:0]  ALU_AND       = 4'h1;
	localparam logic [3:0]  ALU_SUB       = 4'h2;
	localparam logic [3:0]  ALU_OR        = 4'h3;
	localparam logic [3:0]  ALU_ADD       = 4'h4;
	localparam logic [3:0]  ALU_XOR       = 4'h5;
	localparam logic [3:0]  ALU_SUBR      = 4'h6;
	localparam logic [3:0]  ALU_PASSA     = 4'h7;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_C1   = 2'b01,
		ST_C2   = 2'b10
	} lux_state_t;

	typedef enum logic [3:0] {
		OP_NOP     = 4'h0,
		OP_SLIT    = 4'h1,
		OP_SALU    = 4'h2,
		OP_UFETCH  = 4'h3,
		OP_UPUSHOP = 4'h4,
		OP_USTORE  = 4'h5,
		OP_USTDROP = 4'h6,
		OP_UOPIN   = 4'h7,
		OP_LPUSHN  = 4'h8,
		OP_LPUSHT  = 4'h9
	} lux_op_t;

endpackage : lux_pkg

// ---- hw/lux_alu.sv ----
// lux_alu: shared alu function table used by the execution unit
`timescale 1ns/100ps
`default_nettype none
module lux_alu (
	// operands
	input  wire logic [15:0] a_i,
	input  wire logic [15:0] b_i,
	// function select
	input  wire logic [3:0]  op_i,
	// result
	output var  logic [15:0] res_o
);

	always_comb begin
		unique case (op_i)
			lux_pkg::ALU_PASSB: res_o = b_i;
			lux_pkg::ALU_AND:   res_o = a_i & b_i;
			lux_pkg::ALU_SUB:   res_o = a_i - b_i;
			lux_pkg::ALU_OR:    res_o = a_i | b_i;
			lux_pkg::ALU_ADD:   res_o = a_i + b_i;
			lux_pkg::ALU_XOR:   res_o = a_i ^ b_i;
			lux_pkg::ALU_SUBR:  res_o = b_i - a_i;
			lux_pkg::ALU_PASSA: res_o = a_i;
			// upper half: complemented forms of the lower half
			4'h8:               res_o = ~b_i;
			4'h9:               res_o = ~(a_i & b_i);
			4'ha:               res_o = ~(a_i - b_i);
			4'hb:               res_o = ~(a_i | b_i);
			4'hc:               res_o = ~(a_i + b_i);
			4'hd:               res_o = ~(a_i ^ b_i);
			4'he:               res_o = ~(b_i - a_i);
			4'hf:               res_o = ~a_i;
		endcase
	end

endmodule : lux_alu
`default_nettype wire

// ---- hw/lux_exec.sv ----
// lux_exec: execution of short literal, user memory and long literal instructions
// Function
// RL1 - short literal, invert clear: 5-bit value into top, next kept, one cycle
// RL2 - short literal, invert set: complement all 16 bits of zero-extended value
// RL3 - short literal bits 15:5 forced to zero before any inversion
// RL4 - short literal alu form: top op literal into top, one cycle, next kept
// RL5 - user accesses hit a 32-word block placed by user page and base
// RL6 - user word offset comes from the 5-bit instruction field
// RL7 - offset is a word index; byte address is twice the field
// RL8 - every user access moves a full 16-bit word, never a byte
// RL9 - user fetch: push next, user word into next; then idle or invert top
// RL10 - user push-op: push next, top into next, top gets old top op word
// RL11 - user store: write top, next kept, invert top after write if set
// RL12 - user store-drop: write top, next into top (maybe inverted), pop into next
// RL13 - user op in place: top op word into top, next ends unchanged, two cycles
// RL14 - long literal operand is the following program word; pc skips it
// RL15 - long push-next: push next, literal into next; then idle or invert top
// RL16 - long push-top: push next, top into next, literal (maybe inverted) into top
// RL17 - the 4-bit alu field is decoded by the shared alu table
// RL18 - user memory answers a read in its first cycle, takes writes at once
`timescale 1ns/100ps
`default_nettype none
module lux_exec (
	// clock and reset
	input  wire logic        REF_CLK_I,
	input  wire logic        RSTN_I,
	// instruction sequencer
	input  wire logic        INSTR_VALID_I,
	input  wire logic [15:0] INSTR_I,
	output var  logic        READY_O,
	output var  logic        DONE_O,
	output var  logic        ILLEGAL_O,
	output var  logic [15:0] PC_O,
	// program memory operand port
	output var  logic [15:0] PM_ADDR_O,
	output var  logic        PM_RD_O,
	input  wire logic [15:0] PM_DATA_I,
	// user data memory
	input  wire logic [3:0]  USER_PAGE_I,
	input  wire logic [15:0] USER_BASE_I,
	output var  logic [19:0] UM_ADDR_O,
	output var  logic        UM_RD_O,
	output var  logic        UM_WR_O,
	output var  logic [15:0] UM_WDATA_O,
	input  wire logic [15:0] UM_RDATA_I,
	// spill stack
	output var  logic        STK_PUSH_O,
	output var  logic        STK_POP_O,
	output var  logic [15:0] STK_WDATA_O,
	input  wire logic [15:0] STK_RDATA_I,
	// visible stack registers
	output var  logic [15:0] TOP_O,
	output var  logic [15:0] NEXT_O
);

	lux_pkg::lux_state_t state_ff;
	lux_pkg::lux_op_t    op_ff;
	lux_pkg::lux_op_t    dec_op;
	logic [15:0]         top_ff;
	logic [15:0]         next_ff;
	logic [15:0]         sav_ff;
	logic [15:0]         pc_ff;
	logic [3:0]          alu_sel_ff;
	logic                inv_ff;
	logic [4:0]          fld_ff;
	logic [15:0]         alu_b;
	logic [15:0]         alu_res;
	logic [15:0]         lit5;
	logic                take;
	logic                last;

	function automatic lux_pkg::lux_op_t decode(input logic [15:0] ins);
		logic [3:0] cls;
		logic [1:0] frm;
		logic [2:0] sub;
		cls = ins[lux_pkg::CLS_MSB:lux_pkg::CLS_LSB];
		frm = ins[lux_pkg::FRM_MSB:lux_pkg::FRM_LSB];
		sub = ins[lux_pkg::SUB_MSB:lux_pkg::SUB_LSB];
		decode = lux_pkg::OP_NOP;
		if (cls == lux_pkg::CLS_SLIT && frm == lux_pkg::FRM_ALU) begin
			decode = (sub == lux_pkg::SUB_LOAD) ? lux_pkg::OP_SLIT : lux_pkg::OP_SALU;
		end else if (cls == lux_pkg::CLS_USER) begin
			if (frm == lux_pkg::FRM_PUSHALU)
				decode = lux_pkg::OP_UPUSHOP;
			else if (frm == lux_pkg::FRM_ALU)
				decode = lux_pkg::OP_UOPIN;
			else if (frm == lux_pkg::FRM_MISC && sub == lux_pkg::SUB_FETCH)
				decode = lux_pkg::OP_UFETCH;
			else if (frm == lux_pkg::FRM_MISC && sub == lux_pkg::SUB_STORE)
				decode = lux_pkg::OP_USTORE;
			else if (frm == lux_pkg::FRM_MISC && sub == lux_pkg::SUB_STDROP)
				decode = lux_pkg::OP_USTDROP;
		end else if (cls == lux_pkg::CLS_LLIT && frm == lux_pkg::FRM_MISC) begin
			if (sub == lux_pkg::SUB_FETCH)
				decode = lux_pkg::OP_LPUSHN;
			else if (sub == lux_pkg::SUB_STORE)
				decode = lux_pkg::OP_LPUSHT;
		end
	endfunction : decode

	function automatic logic is_two_cycle(input lux_pkg::lux_op_t op);
		is_two_cycle = !(op == lux_pkg::OP_SLIT || op == lux_pkg::OP_SALU ||
			op == lux_pkg::OP_NOP);
	endfunction : is_two_cycle

	function automatic logic is_user_rd(input lux_pkg::lux_op_t op);
		is_user_rd = (op == lux_pkg::OP_UFETCH || op == lux_pkg::OP_UPUSHOP ||
			op == lux_pkg::OP_UOPIN);
	endfunction : is_user_rd

	function automatic logic is_user_wr(input lux_pkg::lux_op_t op);
		is_user_wr = (op == lux_pkg::OP_USTORE || op == lux_pkg::OP_USTDROP);
	endfunction : is_user_wr

	// ops that spill next in their first cycle
	function automatic logic is_push(input lux_pkg::lux_op_t op);
		is_push = (op == lux_pkg::OP_UFETCH || op == lux_pkg::OP_UPUSHOP ||
			op == lux_pkg::OP_LPUSHN || op == lux_pkg::OP_LPUSHT);
	endfunction : is_push

	// only long literals own a second program word
	function automatic logic is_long(input lux_pkg::lux_op_t op);
		is_long = (op == lux_pkg::OP_LPUSHN || op == lux_pkg::OP_LPUSHT);
	endfunction : is_long

	assign dec_op = decode(INSTR_I);
	// ready and idle move together, so take needs no ready term
	assign take   = (state_ff == lux_pkg::ST_IDLE) && INSTR_VALID_I;
	assign last   = (state_ff == lux_pkg::ST_C2) ||
		(state_ff == lux_pkg::ST_C1 && !is_two_cycle(op_ff));
	assign lit5   = {11'h000, fld_ff}; // [RL3]

	// second alu operand: literal for the short form, held user word otherwise
	assign alu_b = (op_ff == lux_pkg::OP_SALU) ? lit5 : next_ff;

	lux_alu u_alu (
		.a_i   (top_ff),
		.b_i   (alu_b),
		.op_i  (alu_sel_ff), // [RL17]
		.res_o (alu_res)
	);

	// sequencing
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			state_ff <= lux_pkg::ST_IDLE;
		end else begin
			unique case (state_ff)
				lux_pkg::ST_IDLE: if (take) state_ff <= lux_pkg::ST_C1;
				lux_pkg::ST_C1:   state_ff <= is_two_cycle(op_ff) ? lux_pkg::ST_C2 : lux_pkg::ST_IDLE;
				lux_pkg::ST_C2:   state_ff <= lux_pkg::ST_IDLE;
				default:          state_ff <= lux_pkg::ST_IDLE;
			endcase
		end
	end

	// instruction fields, latched when taken
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			op_ff      <= lux_pkg::OP_NOP;
			alu_sel_ff <= 4'h0;
			inv_ff     <= 1'b0;
			fld_ff     <= 5'h00;
		end else if (take) begin
			op_ff      <= dec_op;
			alu_sel_ff <= INSTR_I[lux_pkg::OPF_MSB:lux_pkg::OPF_LSB];
			inv_ff     <= INSTR_I[lux_pkg::INV_BIT];
			fld_ff     <= INSTR_I[lux_pkg::FLD_W-1:0]; // [RL6]
		end
	end

	// sequencer handshake
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			READY_O   <= 1'b1;
			DONE_O    <= 1'b0;
			ILLEGAL_O <= 1'b0;
		end else begin
			READY_O   <= take ? 1'b0 : (READY_O | last);
			DONE_O    <= last;
			// an undecodable word still runs one cycle as a no-op
			ILLEGAL_O <= take && (dec_op == lux_pkg::OP_NOP);
		end
	end

	// program counter and long literal operand fetch
	// pc names the opcode being taken; the operand sits right behind it
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			pc_ff     <= lux_pkg::PC_RST;
			PM_ADDR_O <= lux_pkg::PC_RST;
			PM_RD_O   <= 1'b0;
		end else begin
			PM_RD_O <= 1'b0;
			if (take) begin
				PM_ADDR_O <= pc_ff + lux_pkg::PC_STEP1; // [RL14]
				if (is_long(dec_op)) begin
					PM_RD_O <= 1'b1;
					pc_ff   <= pc_ff + lux_pkg::PC_STEP2; // [RL14]
				end else begin
					pc_ff   <= pc_ff + lux_pkg::PC_STEP1;
				end
			end
		end
	end

	// user memory request, presented in the first execution cycle
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			UM_ADDR_O  <= 20'h00000;
			UM_RD_O    <= 1'b0;
			UM_WR_O    <= 1'b0;
			UM_WDATA_O <= 16'h0000;
		end else begin
			UM_RD_O <= 1'b0;
			UM_WR_O <= 1'b0;
			if (take) begin
				// base aligned to the 64-byte block, word index times two
				UM_ADDR_O <= {USER_PAGE_I, USER_BASE_I[15:lux_pkg::UBASE_LSB],
					INSTR_I[lux_pkg::FLD_W-1:0], 1'b0}; // [RL5] [RL7]
				UM_RD_O   <= is_user_rd(dec_op); // [RL18]
				UM_WR_O   <= is_user_wr(dec_op);
				// top as it stands at take; any inversion comes later
				UM_WDATA_O <= top_ff; // [RL8] [RL11] [RL12]
			end
		end
	end

	// top, next and held operand
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			top_ff  <= lux_pkg::TOP_RST;
			next_ff <= lux_pkg::NEXT_RST;
			sav_ff  <= lux_pkg::NEXT_RST;
		end else if (state_ff == lux_pkg::ST_C1) begin
			unique case (op_ff)
				lux_pkg::OP_SLIT:    top_ff <= inv_ff ? ~lit5 : lit5; // [RL1] [RL2]
				lux_pkg::OP_SALU:    top_ff <= alu_res; // [RL4]
				lux_pkg::OP_UFETCH:  next_ff <= UM_RDATA_I; // [RL9] [RL8]
				lux_pkg::OP_UPUSHOP: next_ff <= UM_RDATA_I; // [RL10]
				lux_pkg::OP_UOPIN: begin
					// park next locally instead of a push/pop round trip
					sav_ff  <= next_ff;
					next_ff <= UM_RDATA_I; // [RL13]
				end
				lux_pkg::OP_LPUSHN:  next_ff <= PM_DATA_I; // [RL15] [RL14]
				lux_pkg::OP_LPUSHT: begin
					next_ff <= top_ff; // [RL16]
					sav_ff  <= PM_DATA_I;
				end
				default: ;
			endcase
		end else if (state_ff == lux_pkg::ST_C2) begin
			// second cycle: top inversions, the store-drop pop, and moves that depend on the first cycle's load
			unique case (op_ff)
				lux_pkg::OP_UFETCH,
				lux_pkg::OP_USTORE,
				lux_pkg::OP_LPUSHN:  if (inv_ff) top_ff <= ~top_ff; // [RL9] [RL11] [RL15]
				lux_pkg::OP_UPUSHOP: begin
					next_ff <= top_ff;
					top_ff  <= alu_res; // [RL10]
				end
				lux_pkg::OP_USTDROP: begin
					top_ff  <= inv_ff ? ~next_ff : next_ff; // [RL12]
					next_ff <= STK_RDATA_I;
				end
				lux_pkg::OP_UOPIN: begin
					top_ff  <= alu_res; // [RL13]
					next_ff <= sav_ff;
				end
				lux_pkg::OP_LPUSHT:  top_ff <= inv_ff ? ~sav_ff : sav_ff; // [RL16]
				default: ;
			endcase
		end
	end

	// spill stack pulses; the stack applies them on the following edge
	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			STK_PUSH_O  <= 1'b0;
			STK_POP_O   <= 1'b0;
			STK_WDATA_O <= 16'h0000;
		end else begin
			STK_PUSH_O <= (state_ff == lux_pkg::ST_C1) && is_push(op_ff); // [RL9] [RL10] [RL15] [RL16]
			// pop lags so next has already read the old stack top
			STK_POP_O  <= (state_ff == lux_pkg::ST_C2) && (op_ff == lux_pkg::OP_USTDROP); // [RL12]
			if (state_ff == lux_pkg::ST_C1)
				STK_WDATA_O <= next_ff;
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (!RSTN_I) begin
			TOP_O  <= lux_pkg::TOP_RST;
			NEXT_O <= lux_pkg::NEXT_RST;
			PC_O   <= lux_pkg::PC_RST;
		end else begin
			// visible copies lag the working registers by one edge
			TOP_O  <= top_ff;
			NEXT_O <= next_ff;
			PC_O   <= pc_ff;
		end
	end

endmodule : lux_exec
`default_nettype wire

// ---- tb/lux_exec_props.sv ----
// lux_exec_props: port-level assertions for the execution unit
`timescale 1ns/100ps
`default_nettype none
module lux_exec_props (
	// clock and reset
	input wire logic        REF_CLK_I,
	input wire logic        RSTN_I,
	// sequencer
	input wire logic        INSTR_VALID_I,
	input wire logic [15:0] INSTR_I,
	input wire logic        READY_O,
	input wire logic        DONE_O,
	// memories and stack
	input wire logic        PM_RD_O,
	input wire logic [3:0]  USER_PAGE_I,
	input wire logic [15:0] USER_BASE_I,
	input wire logic [19:0] UM_ADDR_O,
	input wire logic        UM_RD_O,
	input wire logic        UM_WR_O,
	input wire logic [15:0] UM_WDATA_O,
	input wire logic        STK_PUSH_O,
	input wire logic        STK_POP_O,
	input wire logic [15:0] STK_WDATA_O,
	input wire logic [15:0] TOP_O,
	input wire logic [15:0] NEXT_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RSTN_I);
	wire logic       tk  = READY_O && INSTR_VALID_I;
	wire logic [3:0] cls = INSTR_I[15:12];
	wire logic [1:0] frm = INSTR_I[7:6];
	wire logic [2:0] sb  = INSTR_I[11:9];
	wire logic       sl  = tk && cls == 4'hb && frm == 2'h2;
	wire logic       us  = tk && cls == 4'hc;
	wire logic       uv  = us && (frm != 2'h1 ? frm != 2'h3 : sb < 3'h3);
	wire logic       ll  = tk && cls == 4'hd && frm == 2'h1 && sb < 3'h2;
	sequence s_one;
		!DONE_O ##1 DONE_O && READY_O;
	endsequence
	sequence s_two;
		!DONE_O [*2] ##1 DONE_O && READY_O;
	endsequence
	a_take_busy: assert property (tk |=> !READY_O) else $error("ready high after take");
	a_short_time: assert property (sl |=> s_one) else $error("short op length");
	a_long_time: assert property (uv || ll |=> s_two) else $error("two-cycle op length");
	a_short_next: assert property (sl |-> ##2 NEXT_O == $past(NEXT_O))
		else $error("next changed by short op");
	a_short_value: assert property (sl && sb == 3'h7 |-> ##3
		TOP_O == ({11'h0, $past(INSTR_I[4:0], 3)} ^ {16{$past(INSTR_I[8], 3)}}))
		else $error("short literal value");
	a_user_addr: assert property (UM_RD_O || UM_WR_O |-> UM_ADDR_O ==
		{$past(USER_PAGE_I), $past(USER_BASE_I[15:6]), $past(INSTR_I[4:0]), 1'b0})
		else $error("user address");
	a_store_data: assert property (us && frm == 2'h1 && sb inside {3'h1, 3'h2} |=>
		UM_WR_O && UM_WDATA_O == TOP_O) else $error("user write data");
	a_lit_fetch: assert property (ll |=> PM_RD_O) else $error("operand not fetched");
	a_fetch_push: assert property (us && frm == 2'h1 && sb == 3'h0 |-> ##2
		STK_PUSH_O && STK_WDATA_O == $past(NEXT_O)) else $error("fetch push");
	a_inplace_quiet: assert property (us && frm == 2'h2 |=>
		(!STK_PUSH_O && !STK_POP_O) [*3]) else $error("stack moved in place op");
endmodule : lux_exec_props
bind lux_exec lux_exec_props u_props (.*);
`default_nettype wire

// ---- tb/lux_mem_model.sv ----
// lux_mem_model: program memory, user memory and spill stack
`timescale 1ns/100ps
`default_nettype none
module lux_mem_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] pm_addr_i,
	input  wire logic        pm_rd_i,
	output var  logic [15:0] pm_data_o,
	input  wire logic [19:0] um_addr_i,
	input  wire logic        um_rd_i,
	input  wire logic        um_wr_i,
	input  wire logic [15:0] um_wdata_i,
	output var  logic [15:0] um_rdata_o,
	input  wire logic        push_i,
	input  wire logic        pop_i,
	input  wire logic [15:0] push_data_i,
	output var  logic [15:0] stk_top_o
);
	logic [15:0] um [32];
	logic [15:0] stk [$];
	logic [15:0] pm_last = 16'h0;
	logic [15:0] um_last = 16'h0;
	// released lines show the inverse of the last word, never a stale copy
	always_comb pm_data_o = pm_rd_i ? {pm_addr_i[7:0], ~pm_addr_i[7:0]} : ~pm_last;
	always_comb um_rdata_o = um_rd_i ? um[um_addr_i[5:1]] : ~um_last;
	initial stk_top_o = 16'hc3c3;
	always @(posedge clk_i) begin
		if (um_wr_i) um[um_addr_i[5:1]] <= um_wdata_i;
		if (um_rd_i) um_last <= um_rdata_o;
		if (pm_rd_i) pm_last <= pm_data_o;
		if (push_i) stk.push_front(push_data_i);
		if (pop_i) void'(stk.pop_front());
		stk_top_o <= stk.size() != 0 ? stk[0] : 16'hc3c3;
	end
endmodule : lux_mem_model
`default_nettype wire

// ---- tb/lux_exec_tb.sv ----
// lux_exec_tb: self-checking bench for the execution unit
`timescale 1ns/100ps
`default_nettype none
module lux_exec_tb;
	logic             REF_CLK_I = 1'b0;
	logic             RSTN_I = 1'b0;
	logic             INSTR_VALID_I = 1'b0;
	logic [15:0]      INSTR_I = 16'h0;
	logic [15:0]      USER_BASE_I = 16'h0;
	logic [3:0]       USER_PAGE_I = 4'h0;
	wire logic [15:0] PM_DATA_I, UM_RDATA_I, STK_RDATA_I, PC_O, PM_ADDR_O;
	wire logic [15:0] UM_WDATA_O, STK_WDATA_O, TOP_O, NEXT_O;
	wire logic        READY_O, DONE_O, ILLEGAL_O, PM_RD_O, UM_RD_O, UM_WR_O;
	wire logic        STK_PUSH_O, STK_POP_O;
	wire logic [19:0] UM_ADDR_O;
	int               mismatches = 0;
	int               cmp_count = 0;
	logic [15:0]      t, n, pc;
	logic [15:0]      stk [$];
	logic [15:0]      uw [32];
	always #2.5 REF_CLK_I = ~REF_CLK_I;
	lux_exec u_dut (.*);
	lux_mem_model u_mem (.clk_i(REF_CLK_I), .pm_addr_i(PM_ADDR_O), .pm_rd_i(PM_RD_O),
		.pm_data_o(PM_DATA_I), .um_addr_i(UM_ADDR_O), .um_rd_i(UM_RD_O), .um_wr_i(UM_WR_O),
		.um_wdata_i(UM_WDATA_O), .um_rdata_o(UM_RDATA_I), .push_i(STK_PUSH_O),
		.pop_i(STK_POP_O), .push_data_i(STK_WDATA_O), .stk_top_o(STK_RDATA_I));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	function automatic logic [15:0] alu(input logic [3:0] op, input logic [15:0] a, b);
		logic [15:0] r;
		case (op[2:0])
			3'h0: r = b;
			3'h1: r = a & b;
			3'h2: r = a - b;
			3'h3: r = a | b;
			3'h4: r = a + b;
			3'h5: r = a ^ b;
			3'h6: r = b - a;
			default: r = a;
		endcase
		return op[3] ? ~r : r;
	endfunction : alu
	// offer one word, expect done after cyc cycles, then compare stack registers and pc
	task automatic run(input logic [15:0] ins, input int cyc);
		int k;
		k = 1;
		@(negedge REF_CLK_I);
		INSTR_I = ins;
		INSTR_VALID_I = 1'b1;
		@(negedge REF_CLK_I);
		INSTR_VALID_I = 1'b0;
		chk("illegal", 16'h0000, 16'(ILLEGAL_O));
		while (DONE_O !== 1'b1 && k < 20) begin
			k++;
			@(negedge REF_CLK_I);
		end
		chk("cycles", 16'(cyc), 16'(k));
		pc = pc + (ins[15:12] == 4'hd ? 16'h0002 : 16'h0001);
		// stack registers reach the ports one edge after done
		@(negedge REF_CLK_I);
		chk("top", t, TOP_O);
		chk("next", n, NEXT_O);
		chk("pc", pc, PC_O);
	endtask : run
	task automatic t_short;
		logic [4:0] d;
		for (int v = 0; v < 4; v++) begin
			d = v[0] ? 5'h1f : 5'h00;
			t = {11'h0, d} ^ {16{v[1]}};
			run({4'hb, 3'h7, v[1], 2'h2, 1'b0, d}, 2);
		end
		for (int op = 0; op < 14; op++) begin
			d = 5'(op + 3);
			t = alu(4'(op), t, {11'h0, d});
			run({4'hb, 4'(op), 2'h2, 1'b0, d}, 2);
		end
	endtask : t_short
	task automatic t_user;
		USER_PAGE_I = 4'h9;
		USER_BASE_I = 16'h1240;
		uw[3] = t;
		t = ~t;
		run({4'hc, 3'h1, 1'b1, 2'h1, 6'h03}, 3);
		uw[31] = t;
		run({4'hc, 3'h1, 1'b0, 2'h1, 6'h1f}, 3);
		stk.push_front(n);
		n = uw[3];
		run({4'hc, 3'h0, 1'b0, 2'h1, 6'h03}, 3);
		stk.push_front(n);
		n = uw[31];
		t = ~t;
		run({4'hc, 3'h0, 1'b1, 2'h1, 6'h1f}, 3);
		stk.push_front(n);
		n = t;
		t = alu(4'h2, t, uw[3]);
		run({4'hc, 4'h2, 2'h0, 6'h03}, 3);
		t = alu(4'h5, t, uw[31]);
		run({4'hc, 4'h5, 2'h2, 6'h1f}, 3);
		for (int i = 1; i >= 0; i--) begin
			uw[i] = t;
			t = n ^ {16{i[0]}};
			n = stk.pop_front();
			run({4'hc, 3'h2, i[0], 2'h1, 6'(i)}, 3);
		end
		stk.push_front(n);
		n = uw[0];
		run({4'hc, 3'h0, 1'b0, 2'h1, 6'h00}, 3);
	endtask : t_user
	task automatic t_long;
		for (int i = 0; i < 2; i++) begin
			stk.push_front(n);
			n = {pc[7:0] + 8'h01, ~(pc[7:0] + 8'h01)};
			t = t ^ {16{i[0]}};
			run({4'hd, 3'h0, i[0], 2'h1, 6'h00}, 3);
			stk.push_front(n);
			n = t;
			t = {pc[7:0] + 8'h01, ~(pc[7:0] + 8'h01)} ^ {16{i[0]}};
			run({4'hd, 3'h1, i[0], 2'h1, 6'h00}, 3);
		end
	endtask : t_long
	// undecodable word: flagged for one cycle, runs as a one-cycle no-op
	task automatic t_bad;
		@(negedge REF_CLK_I);
		INSTR_I = 16'h0000;
		INSTR_VALID_I = 1'b1;
		@(negedge REF_CLK_I);
		INSTR_VALID_I = 1'b0;
		chk("illegal", 16'h0001, 16'(ILLEGAL_O));
		pc = pc + 16'h0001;
		repeat (2) @(negedge REF_CLK_I);
		chk("pc", pc, PC_O);
		chk("top", t, TOP_O);
		chk("next", n, NEXT_O);
	endtask : t_bad
	task automatic conclude;
		if (mismatches == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : conclude
	initial begin
		repeat (5) @(negedge REF_CLK_I);
		RSTN_I = 1'b1;
		t = 16'h0;
		n = 16'h0;
		pc = 16'h0;
		t_short;
		t_user;
		t_long;
		t_bad;
		conclude;
	end
	// 32 words of a few cycles each; over ten times that is a hang
	initial begin
		#10000;
		mismatches++;
		conclude;
	end
endmodule : lux_exec_tb
`default_nettype wire
